// ==== encoder_status_readback.sv ====
// Overview of operation
// [R01] Answer two-wire reads at slave address 89h with the status byte.
// [R02] Bits 7..5 carry the three-bit programming-model version code.
// [R03] Bit 4 sets when odd-field caption bytes have been encoded.
// [R04] Bit 4 clears after new odd caption data written to 67h and 68h.
// [R05] Bit 3 sets when even-field caption bytes have been encoded.
// [R06] Bit 3 clears after new even caption data written to 69h and 6Ah.
// [R07] Bit 2 is unused and always reads zero.
// [R08] Bit 1 is one only in first field of 4/8/12 field sequence.
// [R09] Bit 0 is one during an even field, zero during odd.
// [R10] Field flags update at field boundaries, sampled coherently at the start of each byte read.
// [R11] Both caption done flags read one after reset.
`timescale 1ns/1ps
module encoder_status_readback #(
  // Arbitrary value
  parameter logic [2:0] VERSION_CODE = 3'h5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Two-wire bus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Encoder events
  input wire logic oddCaptionEncoded,
  input wire logic evenCaptionEncoded,
  input wire logic fieldStart,
  input wire enc_status_pkg::video_std_type videoStd,
  // Control register writes
  input wire logic ctrlWriteStrobe,
  input wire logic [7:0] ctrlWriteAddr,
  // Observation
  output logic [7:0] statusView
);
  import enc_status_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_CHK,
    ST_ACK_OUT,
    ST_TX,
    ST_GET_ACK,
    ST_SKIP
  } bus_state_type;

  typedef struct packed {
    bus_state_type state;
    logic [2:0] bitCnt;
    logic [7:0] shift;
    logic sdaOe;
    logic sdaOut;
    logic sclPrev;
    logic sdaPrev;
    logic [3:0] fieldCnt;
    logic oddDone;
    logic evenDone;
    logic oddFirstSeen;
    logic oddSecondSeen;
    logic evenFirstSeen;
    logic evenSecondSeen;
    logic [7:0] statusView;
  } state_type;

  state_type state_reg;
  state_type state_next;
  logic [1:0] pinSync;
  logic sclS;
  logic sdaS;

  two_flop_sync #(.WIDTH(2)) u_pin_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .asyncIn({sclIn, sdaIn}),
    .syncOut(pinSync)
  );

  assign sclS = pinSync[1];
  assign sdaS = pinSync[0];

  function automatic logic [3:0] seqLen(input video_std_type s);
    if (s == STD_PAL) begin
      seqLen = SEQ_LEN_PAL;
    end else if (s == STD_SECAM) begin
      seqLen = SEQ_LEN_SECAM;
    end else begin
      seqLen = SEQ_LEN_NTSC;
    end
  endfunction

  function automatic logic [7:0] buildStatus(input state_type s);
    logic [7:0] b;
    b = 8'h00;
    // [R02] version code
    b[VER_MSB:VER_LSB] = VERSION_CODE;
    b[ODD_DONE_BIT] = s.oddDone;
    b[EVEN_DONE_BIT] = s.evenDone;
    // [R07] unused reads zero
    b[UNUSED_BIT] = 1'b0;
    // [R08] first field flag
    b[FIRST_FIELD_BIT] = (s.fieldCnt == FIELD_CNT_RESET);
    // [R09] even field parity
    b[EVEN_FIELD_BIT] = s.fieldCnt[0];
    buildStatus = b;
  endfunction

  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;

  assign sclRise = sclS & ~state_reg.sclPrev;
  assign sclFall = ~sclS & state_reg.sclPrev;
  assign startCond = sclS & state_reg.sclPrev & state_reg.sdaPrev & ~sdaS;
  assign stopCond = sclS & state_reg.sclPrev & ~state_reg.sdaPrev & sdaS;

  always_comb begin
    state_next = state_reg;
    state_next.sclPrev = sclS;
    state_next.sdaPrev = sdaS;
    state_next.sdaOut = 1'b0;

    // [R10] field counter update
    if (fieldStart) begin
      if (state_reg.fieldCnt >= seqLen(videoStd) - 4'h1) begin
        state_next.fieldCnt = FIELD_CNT_RESET;
      end else begin
        state_next.fieldCnt = state_reg.fieldCnt + 4'h1;
      end
    end

    // Both bytes of a pair must land before the flag drops
    if (ctrlWriteStrobe) begin
      if (ctrlWriteAddr == CC_ODD_FIRST) begin
        state_next.oddFirstSeen = 1'b1;
      end else if (ctrlWriteAddr == CC_ODD_SECOND) begin
        state_next.oddSecondSeen = 1'b1;
      end else if (ctrlWriteAddr == CC_EVEN_FIRST) begin
        state_next.evenFirstSeen = 1'b1;
      end else if (ctrlWriteAddr == CC_EVEN_SECOND) begin
        state_next.evenSecondSeen = 1'b1;
      end
    end
    // [R04] odd clear on pair
    if (state_next.oddFirstSeen && state_next.oddSecondSeen) begin
      state_next.oddFirstSeen = 1'b0;
      state_next.oddSecondSeen = 1'b0;
      state_next.oddDone = 1'b0;
    end
    // [R06] even clear on pair
    if (state_next.evenFirstSeen && state_next.evenSecondSeen) begin
      state_next.evenFirstSeen = 1'b0;
      state_next.evenSecondSeen = 1'b0;
      state_next.evenDone = 1'b0;
    end
    // [R03] odd set wins over clear
    if (oddCaptionEncoded) begin
      state_next.oddDone = 1'b1;
    end
    // [R05] even set wins over clear
    if (evenCaptionEncoded) begin
      state_next.evenDone = 1'b1;
    end

    state_next.statusView = buildStatus(state_reg);

    // [R01] slave transmitter sequencing
    if (startCond) begin
      state_next.state = ST_ADDR;
      state_next.bitCnt = 3'h0;
      state_next.sdaOe = 1'b0;
    end else if (stopCond) begin
      state_next.state = ST_IDLE;
      state_next.sdaOe = 1'b0;
    end else begin
      case (state_reg.state)
        ST_ADDR: begin
          if (sclRise) begin
            state_next.shift = {state_reg.shift[6:0], sdaS};
            state_next.bitCnt = state_reg.bitCnt + 3'h1;
            if (state_reg.bitCnt == 3'h7) begin
              state_next.state = ST_ADDR_CHK;
            end
          end
        end
        ST_ADDR_CHK: begin
          if (sclFall) begin
            // [R01] match read address
            if (state_reg.shift == READ_ADDR) begin
              state_next.sdaOe = 1'b1;
              state_next.state = ST_ACK_OUT;
            end else begin
              state_next.state = ST_SKIP;
            end
          end
        end
        ST_ACK_OUT: begin
          if (sclFall) begin
            // [R10] coherent snapshot at byte start
            state_next.shift = buildStatus(state_reg);
            state_next.sdaOe = ~state_next.shift[7];
            state_next.bitCnt = 3'h0;
            state_next.state = ST_TX;
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (state_reg.bitCnt == 3'h7) begin
              state_next.sdaOe = 1'b0;
              state_next.state = ST_GET_ACK;
            end else begin
              state_next.shift = {state_reg.shift[6:0], 1'b0};
              state_next.sdaOe = ~state_reg.shift[6];
              state_next.bitCnt = state_reg.bitCnt + 3'h1;
            end
          end
        end
        ST_GET_ACK: begin
          // Master ack asks for the byte again, nack ends the read
          if (sclRise) begin
            state_next.state = sdaS ? ST_SKIP : ST_ACK_OUT;
          end
        end
        default: begin
          state_next.sdaOe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg.state <= ST_IDLE;
      state_reg.bitCnt <= 3'h0;
      state_reg.shift <= 8'h00;
      state_reg.sdaOe <= 1'b0;
      state_reg.sdaOut <= 1'b0;
      state_reg.sclPrev <= 1'b1;
      state_reg.sdaPrev <= 1'b1;
      state_reg.fieldCnt <= FIELD_CNT_RESET;
      // [R11] caption flags reset high
      state_reg.oddDone <= CAPTION_DONE_RESET;
      state_reg.evenDone <= CAPTION_DONE_RESET;
      state_reg.oddFirstSeen <= 1'b0;
      state_reg.oddSecondSeen <= 1'b0;
      state_reg.evenFirstSeen <= 1'b0;
      state_reg.evenSecondSeen <= 1'b0;
      state_reg.statusView <= 8'h00;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sdaOut = state_reg.sdaOut;
  assign sdaOe = state_reg.sdaOe;
  assign statusView = state_reg.statusView;

endmodule

// ==== enc_status_pkg.sv ====
package enc_status_pkg;

  // Two-wire bus
  localparam logic [7:0] READ_ADDR = 8'h89;
  localparam logic [7:0] STATUS_SUBADDR = 8'h00;

  // Caption data subaddresses
  localparam logic [7:0] CC_ODD_FIRST = 8'h67;
  localparam logic [7:0] CC_ODD_SECOND = 8'h68;
  localparam logic [7:0] CC_EVEN_FIRST = 8'h69;
  localparam logic [7:0] CC_EVEN_SECOND = 8'h6A;

  // Status byte field positions
  localparam int VER_MSB = 7;
  localparam int VER_LSB = 5;
  localparam int ODD_DONE_BIT = 4;
  localparam int EVEN_DONE_BIT = 3;
  localparam int UNUSED_BIT = 2;
  localparam int FIRST_FIELD_BIT = 1;
  localparam int EVEN_FIELD_BIT = 0;

  // Reset values
  localparam logic CAPTION_DONE_RESET = 1'b1;
  localparam logic [3:0] FIELD_CNT_RESET = 4'h0;

  // Colour field sequence lengths
  localparam logic [3:0] SEQ_LEN_NTSC = 4'h4;
  localparam logic [3:0] SEQ_LEN_PAL = 4'h8;
  localparam logic [3:0] SEQ_LEN_SECAM = 4'hC;

  typedef enum logic [1:0] {
    STD_NTSC,
    STD_PAL,
    STD_SECAM
  } video_std_type;

endpackage

// ==== two_flop_sync.sv ====
`timescale 1ns/1ps
module two_flop_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;

  // Idle bus level is high, so both stages reset to one
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          stage1_reg[i] <= 1'b1;
          syncOut[i] <= 1'b1;
        end else begin
          stage1_reg[i] <= asyncIn[i];
          syncOut[i] <= stage1_reg[i];
        end
      end
    end
  endgenerate

endmodule

// ==== encoder_status_readback_asserts.sv ====
`timescale 1ns/1ps
module encoder_status_readback_chk
  import enc_status_pkg::*;
#(
  parameter logic [2:0] VERSION_CODE = 3'h5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // Events
  input wire logic oddCaptionEncoded,
  input wire logic evenCaptionEncoded,
  input wire logic fieldStart,
  input wire enc_status_pkg::video_std_type videoStd,
  input wire logic ctrlWriteStrobe,
  input wire logic [7:0] ctrlWriteAddr,
  // Observation
  input wire logic [7:0] statusView
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence wrAt(logic [7:0] a);
    ctrlWriteStrobe && ctrlWriteAddr == a;
  endsequence
  sequence oddPair;
    wrAt(CC_ODD_FIRST) ##[1:20] wrAt(CC_ODD_SECOND);
  endsequence
  // Reverse order on purpose, either order clears
  sequence evenPair;
    wrAt(CC_EVEN_SECOND) ##[1:20] wrAt(CC_EVEN_FIRST);
  endsequence
  a_unused_zero: assert property (statusView[UNUSED_BIT] == 1'b0)
    else $error("unused bit set");
  a_version_code: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |-> statusView[7:5] == VERSION_CODE)
    else $error("version field wrong");
  a_reset_flags: assert property ($fell(sys_rst) |-> ##2 statusView[4:3] == 2'b11)
    else $error("caption flags not set after reset");
  a_odd_set: assert property (oddCaptionEncoded |-> ##[1:3] statusView[ODD_DONE_BIT])
    else $error("odd flag not set");
  a_even_set: assert property (evenCaptionEncoded |-> ##[1:3] statusView[EVEN_DONE_BIT])
    else $error("even flag not set");
  a_odd_clear: assert property (oddPair |-> ##[1:3] !statusView[ODD_DONE_BIT])
    else $error("odd flag not cleared");
  a_even_clear: assert property (evenPair |-> ##[1:3] !statusView[EVEN_DONE_BIT])
    else $error("even flag not cleared");
  a_first_odd: assert property (statusView[FIRST_FIELD_BIT] |-> !statusView[EVEN_FIELD_BIT])
    else $error("first field marked even");
  a_parity_flip: assert property (fieldStart |-> ##2 statusView[0] != $past(statusView[0], 2))
    else $error("parity did not flip");
  a_drive_low: assert property ($changed(sdaOe) |-> !sclIn && sdaOut == 1'b0)
    else $error("data changed with clock high");
endmodule

// ==== status_bus_master.sv ====
`timescale 1ns/1ps
module status_bus_master #(
  parameter int HALF = 6
) (
  // Clock
  input wire logic clk,
  // Bus wires
  input wire logic sdaLine,
  output logic sclPin,
  output logic sdaPull
);
  initial begin
    sclPin = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves only while the clock is low
  task automatic pulse(input logic low, output logic s);
    cyc(1);
    sdaPull <= low;
    cyc(HALF);
    sclPin <= 1'b1;
    cyc(HALF - 1);
    s = sdaLine;
    cyc(1);
    sclPin <= 1'b0;
  endtask
  // address byte, acknowledge, one or two bytes, then stop
  task automatic readByte(input logic [7:0] addr, input logic twoBytes, output logic ack, output logic [7:0] data);
    logic s;
    data = 8'h00;
    cyc(HALF);
    sdaPull <= 1'b1;
    cyc(HALF);
    sclPin <= 1'b0;
    for (int i = 7; i >= 0; i--) pulse(!addr[i], s);
    pulse(1'b0, s);
    ack = !s;
    if (ack) begin
      for (int k = 0; k <= int'(twoBytes); k++) begin
        for (int i = 7; i >= 0; i--) begin
          pulse(1'b0, s);
          data[i] = s;
        end
        // Master ack asks for a fresh byte, release ends the read
        pulse(k < int'(twoBytes), s);
      end
    end
    cyc(1);
    sdaPull <= 1'b1;
    cyc(HALF);
    sclPin <= 1'b1;
    cyc(HALF);
    sdaPull <= 1'b0;
    cyc(HALF);
  endtask
endmodule

// ==== encoder_status_readback_tb.sv ====
`timescale 1ns/1ps
module encoder_status_readback_tb;
  import enc_status_pkg::*;
  // Arbitrary value
  localparam logic [2:0] VER = 3'h2;
  logic clk, sys_rst, oddEnc, evenEnc, fieldStart, wrStrobe, sdaOut, sdaOe, sclPin, sdaPull;
  logic [7:0] wrAddr, statusView;
  video_std_type videoStd;
  wire logic sdaLine;
  int miscompares, checked, cnt;
  logic oddF, evenF;
  assign sdaLine = !(sdaPull || (sdaOe && !sdaOut));
  encoder_status_readback #(.VERSION_CODE(VER)) dut_u (.clk(clk), .sys_rst(sys_rst), .sclIn(sclPin),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .oddCaptionEncoded(oddEnc),
    .evenCaptionEncoded(evenEnc), .fieldStart(fieldStart), .videoStd(videoStd),
    .ctrlWriteStrobe(wrStrobe), .ctrlWriteAddr(wrAddr), .statusView(statusView));
  status_bus_master host_u (.clk(clk), .sdaLine(sdaLine), .sclPin(sclPin), .sdaPull(sdaPull));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [7:0] st();
    return {VER, oddF, evenF, 1'b0, cnt == 0, cnt[0]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("Mismatches %0d, checks %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic readChk(input logic twoBytes);
    logic a;
    logic [7:0] d;
    host_u.readByte(READ_ADDR, twoBytes, a, d);
    chk8({7'h00, a}, 8'h01);
    chk8(d, st());
  endtask
  task automatic t_bad_addr(input logic [7:0] addr);
    logic a;
    logic [7:0] d;
    host_u.readByte(addr, 1'b0, a, d);
    chk8({7'h00, a}, 8'h00);
  endtask
  task automatic t_caption(input logic [7:0] a1, input logic [7:0] a2, input logic isOdd);
    wrStrobe <= 1'b1;
    wrAddr <= a1;
    cyc(1);
    wrStrobe <= 1'b0;
    cyc(4);
    chk8(statusView, st());
    wrStrobe <= 1'b1;
    wrAddr <= a2;
    cyc(1);
    wrStrobe <= 1'b0;
    cyc(4);
    if (isOdd) oddF = 1'b0;
    else evenF = 1'b0;
    chk8(statusView, st());
    readChk(1'b0);
    if (isOdd) oddEnc <= 1'b1;
    else evenEnc <= 1'b1;
    cyc(1);
    oddEnc <= 1'b0;
    evenEnc <= 1'b0;
    cyc(4);
    if (isOdd) oddF = 1'b1;
    else evenF = 1'b1;
    chk8(statusView, st());
  endtask
  task automatic t_fields(input video_std_type std, input int len);
    videoStd <= std;
    repeat (2 * len) begin
      fieldStart <= 1'b1;
      cyc(1);
      fieldStart <= 1'b0;
      cnt = (cnt >= len - 1) ? 0 : cnt + 1;
      cyc(3);
      chk8(statusView, st());
    end
  endtask
  initial begin
    #500000;
    miscompares++;
    stop_test();
  end
  initial begin
    {sys_rst, oddF, evenF} = 3'b111;
    {oddEnc, evenEnc, fieldStart, wrStrobe} = 4'h0;
    {wrAddr, cnt} = '0;
    videoStd = STD_NTSC;
    cyc(8);
    sys_rst <= 1'b0;
    cyc(4);
    chk8(statusView, st());
    readChk(1'b0);
    t_bad_addr(8'h88);
    t_bad_addr(8'h8B);
    t_caption(CC_ODD_FIRST, CC_ODD_SECOND, 1'b1);
    t_caption(CC_EVEN_SECOND, CC_EVEN_FIRST, 1'b0);
    t_fields(STD_NTSC, 4);
    t_fields(STD_PAL, 8);
    t_fields(STD_SECAM, 12);
    readChk(1'b1);
    stop_test();
  end
endmodule
bind encoder_status_readback encoder_status_readback_chk #(.VERSION_CODE(VERSION_CODE)) chk_u (
  .clk(clk), .sys_rst(sys_rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .oddCaptionEncoded(oddCaptionEncoded), .evenCaptionEncoded(evenCaptionEncoded),
  .fieldStart(fieldStart), .videoStd(videoStd), .ctrlWriteStrobe(ctrlWriteStrobe),
  .ctrlWriteAddr(ctrlWriteAddr), .statusView(statusView));
